/* File: rtl/pss_regs.vh */
// Timing constants for the enable / power-good sequencer.
// Assumes a single core clock; every delay is counted in 1 ms ticks.
// Overview of operation
// - While the synchronised enable request is high or floating, main stays off; standby ignores it.
// - Main is regulated no sooner than 5 ms and no later than 400 ms after the request goes low.
// - After the request is released, main is switched off within 5 ms.
// - After the request is released, power-good drops within 5 ms (the looser reading allows 50 ms).
// - Power-good asserts 100 ms to 500 ms after all outputs reach regulation (1000 ms looser limit).
// - Power-good falls at least 1 ms before the main rail leaves regulation at shutdown; on a latch-off the code drops main one clock cycle after it.
// - Power-good stays low at least 100 ms in any off/on cycle before it rises again.
// - At AC turn-on main reaches regulation 50 ms to 1000 ms after standby is regulated.
// - Standby is regulated no later than 1500 ms after AC is applied.
// - With the request held active, all outputs are regulated within 3000 ms of AC.
// - On AC loss power-good stays high at least 12 ms while outputs last at least 13 ms.
// - Power-good is high only while all outputs are regulated and falls on undervoltage, fault or long AC loss.
// - The power-good delay does not run while the main output is in current limit.
// - Main ramps from 10 percent to regulation in 5-70 ms and standby in 1-25 ms.
// - A protection latch-off clears after the request is high for 1 s or AC is gone for 15 s.
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// Clock and tick periods
`define PSS_CLK_PERIOD_NS      5
`define PSS_TICK_PERIOD_NS     1000000

// Delays in milliseconds (ticks)
`define PSS_REQ_TO_REG_MIN_MS  5
`define PSS_REQ_TO_REG_MAX_MS  400
`define PSS_GOOD_ASSERT_MS     100
`define PSS_GOOD_LOW_MIN_MS    100
`define PSS_SB_TO_MAIN_MIN_MS  50
`define PSS_SB_REG_MAX_MS      1500
`define PSS_HOLDUP_MS          12
`define PSS_LATCH_HIGH_MS      1000
`define PSS_LATCH_ACOFF_MS     15000
// Two ticks guarantee at least 1 ms whatever the tick phase
`define PSS_DROP_LEAD_TICKS    2

// Timer width, holds the longest count above
`define PSS_TIMER_W            14

`endif

/* File: rtl/pss_ms_timer.v */
// Saturating millisecond counter advanced by a shared tick.
// Assumes tick is a one-cycle pulse in the core clock domain.
`default_nettype none

module pss_ms_timer #(
    parameter W = 14
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst_b,
    // Control
    input  wire         tick,
    input  wire         clear,
    input  wire         run,
    // Elapsed ticks
    output reg  [W-1:0] count_q
);

    wire [W-1:0] count_max = {W{1'b1}};

    // Clear wins; saturate so a long wait never wraps to a short one
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= {W{1'b0}};
        end else if (clear) begin
            count_q <= {W{1'b0}};
        end else if (run && tick && count_q != count_max) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // pss_ms_timer

`default_nettype wire

/* File: rtl/pss_sequencer.v */
// Enable / power-good sequencer of a redundant power module.
// Assumes rail sense and fault inputs are synchronous to core_clk;
// only the host enable request is treated as asynchronous.
`include "pss_regs.vh"
`default_nettype none

module pss_sequencer #(
    parameter TICK_CYCLES = `PSS_TICK_PERIOD_NS / `PSS_CLK_PERIOD_NS,
    parameter TW          = `PSS_TIMER_W
) (
    // Clock and reset
    input  wire core_clk,
    input  wire rst_b,
    // Host enable request, active low, pulled high when open
    input  wire enable_req_b,
    // Power stage sense
    input  wire ac_present,
    input  wire standby_rail_good,
    input  wire main_rail_good,
    input  wire main_curr_limit,
    input  wire prot_trip,
    input  wire internal_fail,
    // Rail enables
    output reg  standby_rail_en,
    output reg  main_rail_en,
    // Open-drain power-good pin
    input  wire outputs_good_alias_in,
    output wire outputs_good_alias_out,
    output wire outputs_good_alias_oe,
    // Status
    output reg  seq_fault,
    output reg  latched_off
);

    localparam S_NOAC      = 3'd0;
    localparam S_SB_RAMP   = 3'd1;
    localparam S_SB_ON     = 3'd2;
    localparam S_MAIN_RAMP = 3'd3;
    localparam S_MAIN_ON   = 3'd4;
    localparam S_DRAIN     = 3'd5;
    localparam S_LATCH     = 3'd6;

    localparam PW = $clog2(TICK_CYCLES + 1);
    // Full-width copy so the narrowing to PW bits is explicit
    localparam [31:0]   TICK_LAST_W = TICK_CYCLES - 1;
    localparam [PW-1:0] TICK_LAST   = TICK_LAST_W[PW-1:0];

    reg  [PW-1:0] pre_q;
    reg           tick_q;
    reg           en_meta_q;
    reg           en_sync_q;
    reg  [2:0]    state_q;
    reg  [2:0]    state_d;
    reg           good_q;
    reg           good_d;
    reg           latch_d;
    reg           seq_fault_d;
    wire          req;
    wire          pg_run;
    wire [TW-1:0] req_ms;
    wire [TW-1:0] hi_ms;
    wire [TW-1:0] ac_ms;
    wire [TW-1:0] sb_ms;
    wire [TW-1:0] low_ms;
    wire [TW-1:0] st_ms;
    wire [TW-1:0] pg_ms;

    // Fixed millisecond tick shared by all timers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q  <= {PW{1'b0}};
            tick_q <= 1'b0;
        end else begin
            tick_q <= (pre_q == TICK_LAST);
            pre_q  <= (pre_q == TICK_LAST) ? {PW{1'b0}}
                                           : pre_q + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    // Two-stage synchroniser; resets to "off" like an open pin
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_meta_q <= 1'b1;
            en_sync_q <= 1'b1;
        end else begin
            en_meta_q <= enable_req_b;
            en_sync_q <= en_meta_q;
        end
    end

    assign req = ~en_sync_q;

    // Good delay only runs while regulated and out of current limit
    assign pg_run = (state_q == S_MAIN_ON) && main_rail_good
                    && !main_curr_limit;

    // Time since request went active
    pss_ms_timer #(.W(TW)) u_req_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (~req),
        .run      (req),
        .count_q  (req_ms)
    );

    // Time the request has been held high
    pss_ms_timer #(.W(TW)) u_hi_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (req),
        .run      (~req),
        .count_q  (hi_ms)
    );

    // Time AC has been absent
    pss_ms_timer #(.W(TW)) u_ac_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (ac_present),
        .run      (~ac_present),
        .count_q  (ac_ms)
    );

    // Time standby has been regulated
    pss_ms_timer #(.W(TW)) u_sb_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (~standby_rail_good),
        .run      (standby_rail_good),
        .count_q  (sb_ms)
    );

    // Time power-good has been low; restarts on every drop
    pss_ms_timer #(.W(TW)) u_low_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (good_q),
        .run      (~good_q),
        .count_q  (low_ms)
    );

    // Time spent in the current state
    pss_ms_timer #(.W(TW)) u_st_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (state_d != state_q),
        .run      (1'b1),
        .count_q  (st_ms)
    );

    // Power-good assertion delay
    pss_ms_timer #(.W(TW)) u_pg_tmr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_q),
        .clear    (~pg_run),
        .run      (pg_run),
        .count_q  (pg_ms)
    );

    // Sequencing decisions
    always @* begin
        state_d     = state_q;
        good_d      = good_q;
        seq_fault_d = seq_fault;
        // Latch clears on a long high request or long AC loss
        latch_d     = latched_off && !(hi_ms >= `PSS_LATCH_HIGH_MS
                      || ac_ms >= `PSS_LATCH_ACOFF_MS);
        case (state_q)
            S_NOAC: begin
                good_d = 1'b0;
                if (ac_present) begin
                    state_d     = S_SB_RAMP;
                    seq_fault_d = 1'b0;
                end
            end
            S_SB_RAMP: begin
                if (!ac_present) begin
                    state_d = S_NOAC;
                end else if (standby_rail_good) begin
                    state_d = S_SB_ON;
                end else if (st_ms >= `PSS_SB_REG_MAX_MS) begin
                    seq_fault_d = 1'b1;
                end
            end
            S_SB_ON: begin
                // Main waits for both request and standby settle time
                if (!ac_present) begin
                    state_d = S_NOAC;
                end else if (req && !latched_off && standby_rail_good
                             && req_ms >= `PSS_REQ_TO_REG_MIN_MS
                             && sb_ms >= `PSS_SB_TO_MAIN_MIN_MS) begin
                    state_d = S_MAIN_RAMP;
                end
            end
            S_MAIN_RAMP: begin
                if (prot_trip || internal_fail) begin
                    state_d = S_LATCH;
                    latch_d = 1'b1;
                end else if (!req || !ac_present) begin
                    state_d = S_DRAIN;
                end else if (main_rail_good) begin
                    state_d = S_MAIN_ON;
                end else if (st_ms >= `PSS_REQ_TO_REG_MAX_MS) begin
                    state_d     = S_LATCH;
                    latch_d     = 1'b1;
                    seq_fault_d = 1'b1;
                end
            end
            S_MAIN_ON: begin
                if (prot_trip || internal_fail || !main_rail_good
                    || !standby_rail_good) begin
                    state_d = S_LATCH;
                    latch_d = 1'b1;
                    good_d  = 1'b0;
                end else if (!req || ac_ms >= `PSS_HOLDUP_MS) begin
                    state_d = S_DRAIN;
                    good_d  = 1'b0;
                end else if (pg_ms >= `PSS_GOOD_ASSERT_MS
                             && low_ms >= `PSS_GOOD_LOW_MIN_MS) begin
                    good_d = 1'b1;
                end
            end
            S_DRAIN: begin
                // Main held on for the lead time after good fell
                good_d = 1'b0;
                if (st_ms >= `PSS_DROP_LEAD_TICKS) begin
                    state_d = ac_present ? S_SB_ON : S_NOAC;
                end
            end
            S_LATCH: begin
                // One cycle with good low before main is dropped
                good_d  = 1'b0;
                state_d = ac_present ? S_SB_ON : S_NOAC;
            end
            default: begin
                state_d = S_NOAC;
                good_d  = 1'b0;
            end
        endcase
    end

    // State and output registers; rail enables follow the state one cycle late
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q         <= S_NOAC;
            good_q          <= 1'b0;
            latched_off     <= 1'b0;
            seq_fault       <= 1'b0;
            standby_rail_en <= 1'b0;
            main_rail_en    <= 1'b0;
        end else begin
            state_q         <= state_d;
            good_q          <= good_d;
            latched_off     <= latch_d;
            seq_fault       <= seq_fault_d;
            standby_rail_en <= (state_q != S_NOAC);
            main_rail_en    <= (state_q == S_MAIN_RAMP)
                            || (state_q == S_MAIN_ON)
                            || (state_q == S_DRAIN);
        end
    end

    // Open drain: pull low unless good; the pin's pull-up gives the high
    assign outputs_good_alias_out = 1'b0;
    assign outputs_good_alias_oe  = ~good_q;

endmodule // pss_sequencer

`default_nettype wire

/* File: verif/pss_sequencer_asserts.sv */
// Port checker for the enable / power-good sequencer.
// Assumes TICK_CYCLES of 4 where a bound is a plain cycle figure.
`default_nettype none

module pss_sequencer_asserts #(parameter int TICK_CYCLES = 4) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Sequencer inputs
    input wire logic enable_req_b,
    input wire logic ac_present,
    input wire logic standby_rail_good,
    input wire logic main_rail_good,
    input wire logic main_curr_limit,
    input wire logic prot_trip,
    // Sequencer outputs
    input wire logic standby_rail_en,
    input wire logic main_rail_en,
    input wire logic outputs_good_alias_oe,
    input wire logic latched_off
);
    logic [15:0] hi_q;
    logic [15:0] ok_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Run lengths of pin-low and of clean main; they saturate, not wrap
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_q <= 16'h0000;
            ok_q <= 16'h0000;
        end else begin
            hi_q <= !outputs_good_alias_oe ? 16'h0000
                  : hi_q + {15'h0000, ~&hi_q};
            ok_q <= (!main_rail_good || main_curr_limit) ? 16'h0000
                  : ok_q + {15'h0000, ~&ok_q};
        end
    end

    a_main_needs_req: assert property ($rose(main_rail_en) |->
        !$past(enable_req_b, 8) && standby_rail_good && !latched_off)
        else $error("main enabled without a held request");
    a_release_drop: assert property ($rose(enable_req_b) |->
        ##[1:6] outputs_good_alias_oe) else $error("good not dropped");
    a_release_off: assert property ($rose(enable_req_b) |->
        ##[1:24] !main_rail_en) else $error("main not off in time");
    a_drop_lead: assert property ($fell(main_rail_en) && enable_req_b
        |-> $past(outputs_good_alias_oe, 4)) else $error("lead too short");
    a_fault_drop: assert property (prot_trip && main_rail_en |=>
        outputs_good_alias_oe ##1 !main_rail_en) else $error("fault order");
    a_good_needs_main: assert property (!outputs_good_alias_oe
        |-> main_rail_en) else $error("good without main");
    a_ungood_drop: assert property ($fell(main_rail_good)
        |=> outputs_good_alias_oe) else $error("good kept on undervoltage");
    a_good_low_min: assert property ($fell(outputs_good_alias_oe)
        |-> hi_q >= 99 * TICK_CYCLES) else $error("good low too short");
    a_good_delay: assert property ($fell(outputs_good_alias_oe)
        |-> ok_q >= 99 * TICK_CYCLES) else $error("good asserted early");
    a_holdup_time: assert property ($fell(ac_present)
        && !outputs_good_alias_oe |-> ##40 !outputs_good_alias_oe)
        else $error("holdup too short");
    a_standby_on: assert property ($rose(ac_present) |->
        ##[1:3] standby_rail_en) else $error("standby not enabled");
endmodule // pss_sequencer_asserts

bind pss_sequencer pss_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES))
    u_pss_sequencer_asserts (.core_clk, .rst_b, .enable_req_b, .ac_present,
    .standby_rail_good, .main_rail_good, .main_curr_limit, .prot_trip,
    .standby_rail_en, .main_rail_en, .outputs_good_alias_oe, .latched_off);

`default_nettype wire

/* File: verif/pss_host_model.sv */
// Power stage and board pull-up facing the sequencer.
// Assumes rails answer their enables in core_clk cycles.
`default_nettype none

module pss_host_model #(parameter int SB_DLY = 40, MAIN_DLY = 60) (
    // Clock
    input  wire logic core_clk,
    // From the sequencer
    input  wire logic standby_rail_en,
    input  wire logic main_rail_en,
    input  wire logic outputs_good_alias_oe,
    // Back to the sequencer and host
    output var  logic standby_rail_good,
    output var  logic main_rail_good,
    output wire logic good_pin
);
    int sb_n = 0;
    int mn_n = 0;

    // Ramps take 10 and 15 ticks; a rail collapses as its enable drops
    always @(posedge core_clk) begin
        sb_n <= standby_rail_en ? sb_n + 1 : 0;
        mn_n <= main_rail_en ? mn_n + 1 : 0;
        standby_rail_good <= standby_rail_en && sb_n >= SB_DLY;
        main_rail_good <= main_rail_en && mn_n >= MAIN_DLY;
    end

    // Board pull-up wins whenever the device lets go
    assign good_pin = outputs_good_alias_oe ? 1'h0 : 1'h1;
endmodule // pss_host_model

`default_nettype wire

/* File: verif/psu_enable_power_good_sequencer_test.sv */
// Self-checking bench for the enable / power-good sequencer.
// Assumes a 1 ms tick shortened to T cycles; figures are in ticks.
`default_nettype none

module psu_enable_power_good_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic core_clk = 1'h0, rst_b = 1'h0, enable_req_b = 1'h1;
    logic ac_present = 1'h0, main_curr_limit = 1'h0, prot_trip = 1'h0;
    logic internal_fail = 1'h0, good_out;
    logic standby_rail_good, main_rail_good, good_pin, oe;
    logic standby_rail_en, main_rail_en, seq_fault, latched_off;
    int errors = 0, comparisons = 0, cyc = 0, t0, t_drop;

    pss_sequencer #(.TICK_CYCLES(T)) u_pss_sequencer (.core_clk(core_clk),
        .rst_b(rst_b), .enable_req_b(enable_req_b), .ac_present(ac_present),
        .standby_rail_good(standby_rail_good), .main_rail_good(main_rail_good),
        .main_curr_limit(main_curr_limit), .prot_trip(prot_trip),
        .internal_fail(internal_fail), .standby_rail_en(standby_rail_en),
        .main_rail_en(main_rail_en), .outputs_good_alias_in(good_pin),
        .outputs_good_alias_out(good_out), .outputs_good_alias_oe(oe),
        .seq_fault(seq_fault), .latched_off(latched_off));
    pss_host_model u_pss_host_model (.core_clk(core_clk),
        .standby_rail_en(standby_rail_en), .main_rail_en(main_rail_en),
        .outputs_good_alias_oe(oe), .standby_rail_good(standby_rail_good),
        .main_rail_good(main_rail_good), .good_pin(good_pin));

    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask

    function logic sig(input int s);
        case (s)
            0: return good_pin;
            1: return main_rail_en;
            2: return main_rail_good;
            3: return standby_rail_good;
            default: return latched_off;
        endcase
    endfunction

    // Bounded wait; a miss is reported as a mismatch
    task wt(input int s, input logic v, input int lim);
        for (int i = 0; i < lim && sig(s) !== v; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("wait", sig(s), v);
    endtask

    task t_ac_on;
        int ts;
        @(posedge core_clk);
        ac_present <= 1'h1;
        enable_req_b <= 1'h0;
        t0 = cyc;
        wt(3, 1'h1, 1500 * T);
        ts = cyc;
        chk("sb_time", cyc - t0 <= 1500 * T, 1'h1);
        wt(2, 1'h1, 1100 * T);
        chk("sb_to_main", cyc - ts >= 50 * T && cyc - ts <= 1000 * T, 1'h1);
        ts = cyc;
        wt(0, 1'h1, 600 * T);
        chk("good_dly", cyc - ts >= 99 * T && cyc - ts <= 500 * T, 1'h1);
        chk("all_on", cyc - t0 <= 3000 * T, 1'h1);
        chk("seq_fault", seq_fault, 1'h0);
    endtask

    task t_release;
        @(posedge core_clk);
        enable_req_b <= 1'h1;
        t0 = cyc;
        wt(0, 1'h0, 60);
        t_drop = cyc;
        chk("good_drop", cyc - t0 <= 5 * T + 4, 1'h1);
        wt(1, 1'h0, 60);
        chk("main_off", cyc - t0 <= 5 * T + 4, 1'h1);
        chk("lead", cyc - t_drop >= T, 1'h1);
        repeat (50) @(posedge core_clk);
        #1;
        chk("stay_off", main_rail_en, 1'h0);
        chk("standby_kept", standby_rail_en, 1'h1);
    endtask

    // Re-enable with current limit holding back the good delay
    task t_reenable;
        @(posedge core_clk);
        enable_req_b <= 1'h0;
        t0 = cyc;
        wt(2, 1'h1, 400 * T);
        chk("on_dly", cyc - t0 >= 5 * T && cyc - t0 <= 400 * T, 1'h1);
        @(posedge core_clk);
        main_curr_limit <= 1'h1;
        repeat (200) @(posedge core_clk);
        main_curr_limit <= 1'h0;
        t0 = cyc;
        wt(0, 1'h1, 600 * T);
        chk("limit_hold", cyc - t0 >= 99 * T, 1'h1);
        chk("low_min", cyc - t_drop >= 99 * T, 1'h1);
    endtask

    task t_fault;
        @(posedge core_clk);
        prot_trip <= 1'h1;
        @(posedge core_clk);
        prot_trip <= 1'h0;
        wt(1, 1'h0, 4);
        chk("good_low", good_pin, 1'h0);
        chk("latched", latched_off, 1'h1);
        repeat (400) @(posedge core_clk);
        #1;
        chk("refused", main_rail_en, 1'h0);
        @(posedge core_clk);
        enable_req_b <= 1'h1;
        t0 = cyc;
        wt(4, 1'h0, 1000 * T + 20);
        chk("unlatch", cyc - t0 >= 999 * T, 1'h1);
        @(posedge core_clk);
        enable_req_b <= 1'h0;
        wt(0, 1'h1, 1000 * T);
    endtask

    task t_ac_loss;
        @(posedge core_clk);
        ac_present <= 1'h0;
        t0 = cyc;
        wt(0, 1'h0, 100 * T);
        t_drop = cyc;
        chk("holdup", cyc - t0 >= 11 * T, 1'h1);
        wt(1, 1'h0, 20 * T);
    endtask

    // AC back with the request held, then an internal failure
    task t_int_fail;
        @(posedge core_clk);
        ac_present <= 1'h1;
        wt(0, 1'h1, 1000 * T);
        chk("cycle_low", cyc - t_drop >= 99 * T, 1'h1);
        chk("od_low", good_out, 1'h0);
        @(posedge core_clk);
        internal_fail <= 1'h1;
        @(posedge core_clk);
        internal_fail <= 1'h0;
        wt(1, 1'h0, 4);
        chk("fail_good", good_pin, 1'h0);
        chk("fail_latch", latched_off, 1'h1);
        chk("no_seq_fault", seq_fault, 1'h0);
    endtask

    task end_sim;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog well beyond the roughly 7000 cycles of the sequence
    initial begin
        repeat (30000) @(posedge core_clk);
        errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'h1;
        t_ac_on();
        t_release();
        t_reenable();
        t_fault();
        t_ac_loss();
        t_int_fail();
        end_sim();
    end
endmodule // psu_enable_power_good_sequencer_test

`default_nettype wire
